// [inc/opdec_consts.vh]
`ifndef OPDEC_CONSTS_VH
`define OPDEC_CONSTS_VH
// register offsets on the plain register port
`define ADDR_W          4
`define OFF_PSW         4'h0
`define OFF_FLAGS       4'h1
`define OFF_CTRL        4'h2
`define OFF_ACT         4'h3
`define OFF_GPR_BASE    4'h8
// status word fields
`define PSW_PRIO_HI     7
`define PSW_PRIO_LO     5
`define PSW_TRACE       4
`define PSW_N           3
`define PSW_Z           2
`define PSW_V           1
`define PSW_C           0
`define PSW_RESET       16'h0000
// error flag register bit positions
`define FLG_BOUND       0
`define FLG_STKOVF      1
`define FLG_TIMEOUT     2
`define FLG_ILLEGAL     3
`define FLG_PWRFAIL     4
`define FLG_PWRUP       5
// stack limit, octal 400
`define STACK_LIMIT     16'h0100
// bus time-out: 10 us at 10 ns per cycle
`define TIMEOUT_NS      10000
`define CLK_NS          10
`define TIMEOUT_CYC     (`TIMEOUT_NS / `CLK_NS)
// activity values
`define ACT_RUN         2'h0
`define ACT_WAIT        2'h1
`define ACT_OFF         2'h2
// opcode of move word and of the one-operand jump
`define OP_MOVE         4'h1
`define OP_UNARY        4'h0
`define UOP_JUMP        10'h001
`define JOP_CALL        7'h04
`endif

// [hdl/field_splitter.v]
`timescale 1ns/1ps
`include "opdec_consts.vh"
// splits an instruction word into its fields; purely combinational
module field_splitter (
    input  wire [15:0] i_instr,
    output wire [3:0]  o_opcode,
    output wire [2:0]  o_src_mode,
    output wire [2:0]  o_src_reg,
    output wire [2:0]  o_dst_mode,
    output wire [2:0]  o_dst_reg,
    output wire        o_is_move,
    output wire        o_is_jump,
    output wire        o_is_byte,
    output wire [15:0] o_branch_offset
);
    wire [5:0] source_specifier_field;
    wire [5:0] destination_specifier_field;

    // two-operand layout
    assign o_opcode                    = i_instr[15:12];
    assign source_specifier_field      = i_instr[11:6];
    assign destination_specifier_field = i_instr[5:0];
    assign o_src_mode = source_specifier_field[5:3];
    assign o_src_reg  = source_specifier_field[2:0];
    assign o_dst_mode = destination_specifier_field[5:3];
    assign o_dst_reg  = destination_specifier_field[2:0];

    // each word hits one class only: jump/call live under opcode 0, move under 1
    assign o_is_move = (i_instr[15:12] == `OP_MOVE);
    assign o_is_jump = (i_instr[15:12] == `OP_UNARY) &&
                       ((i_instr[15:6] == `UOP_JUMP) ||
                        (i_instr[15:9] == `JOP_CALL));
    // top bit set on a two-operand code marks the byte variant
    assign o_is_byte = i_instr[15] && (i_instr[14:12] != 3'h0) && (i_instr[14:12] != 3'h7);

    // branch displacement, sign extended
    assign o_branch_offset = {{8{i_instr[7]}}, i_instr[7:0]};
endmodule

// [hdl/cc_flags.v]
`timescale 1ns/1ps
// condition code generation from a 17-bit result
module cc_flags (
    input  wire [16:0] i_result,
    input  wire        i_ovf,
    input  wire        i_is_move,
    output wire        o_n,
    output wire        o_z,
    output wire        o_v,
    output wire        o_c
);
    // a move clears overflow; carry comes from bit 16 of the wide result
    assign o_n = i_result[15];
    assign o_z = (i_result[15:0] == 16'h0000);
    assign o_v = i_is_move ? 1'b0 : i_ovf;
    assign o_c = i_result[16];
endmodule

// [hdl/operand_address_decoder.v]
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "opdec_consts.vh"
module operand_address_decoder #(
    parameter TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    input  wire                 i_clk,
    input  wire                 i_reset,
    input  wire                 i_ce,
    input  wire [`ADDR_W-1:0]   i_reg_addr,
    input  wire [15:0]          i_reg_wdata,
    input  wire                 i_reg_wr,
    input  wire                 i_reg_rd,
    output reg  [15:0]          o_reg_rdata,
    output wire                 o_mem_req,
    output wire                 o_mem_we,
    output wire [15:0]          o_mem_addr,
    output wire [15:0]          o_mem_wdata,
    input  wire                 i_mem_ack,
    input  wire [15:0]          i_mem_rdata,
    input  wire                 i_power_low,
    input  wire                 i_power_ok,
    output wire                 o_trace_trap,
    output wire [1:0]           o_activity,
    output wire                 o_busy
);
    // sequencer states
    localparam ST_IDLE  = 4'h0;
    localparam ST_FETCH = 4'h1;
    localparam ST_DEC   = 4'h2;
    localparam ST_NEXTW = 4'h3;
    localparam ST_PTR   = 4'h4;
    localparam ST_OPRD  = 4'h5;
    localparam ST_WRITE = 4'h6;
    localparam ST_DONE  = 4'h7;
    localparam ST_SRC   = 1'b0;
    localparam ST_DST   = 1'b1;

    reg  [15:0] gpr_r [0:7];
    reg  [15:0] psw_r;
    reg  [5:0]  flags_r;
    reg  [1:0]  act_r;
    reg  [3:0]  st_r;
    reg         phase_r;
    reg  [15:0] instr_r;
    reg  [15:0] ea_r;
    reg  [15:0] src_val_r;
    reg  [15:0] dst_val_r;
    reg  [15:0] maddr_r;
    reg         mwe_r;
    reg  [15:0] mwdata_r;
    reg  [15:0] tmo_cnt_r;
    reg  [2:0]  pf_sync_r;
    reg  [2:0]  pu_sync_r;
    reg         pf_last_r;
    reg         pu_last_r;
    reg         is_byte_access;
    integer     j;

    wire [3:0]  opcode;
    wire [2:0]  src_mode;
    wire [2:0]  src_reg;
    wire [2:0]  dst_mode;
    wire [2:0]  dst_reg;
    wire        is_move;
    wire        is_jump;
    wire        is_byte;
    wire [15:0] branch_offset;
    wire        cc_n;
    wire        cc_z;
    wire        cc_v;
    wire        cc_c;

    field_splitter u_split (
        .i_instr         (instr_r),
        .o_opcode        (opcode),
        .o_src_mode      (src_mode),
        .o_src_reg       (src_reg),
        .o_dst_mode      (dst_mode),
        .o_dst_reg       (dst_reg),
        .o_is_move       (is_move),
        .o_is_jump       (is_jump),
        .o_is_byte       (is_byte),
        .o_branch_offset (branch_offset)
    );

    // current specifier
    wire [2:0]  cur_mode = (phase_r == ST_SRC) ? src_mode : dst_mode;
    wire [2:0]  cur_reg  = (phase_r == ST_SRC) ? src_reg  : dst_reg;
    wire [15:0] selected_register = gpr_r[cur_reg];
    wire        cur_word = ~is_byte | (cur_mode[0]) | (cur_reg[2:1] == 2'b11);
    // stack pointer and program counter always step by two
    wire [15:0] operand_step = (is_byte && (cur_reg[2:1] != 2'b11)) ? 16'h0001
                                                                     : 16'h0002;
    wire [15:0] following_word = i_mem_rdata;
    wire        jump_dst = is_jump && (phase_r == ST_DST);

    cc_flags u_cc (
        .i_result  ({1'b0, src_val_r}),
        .i_ovf     (1'b0),
        .i_is_move (is_move),
        .o_n       (cc_n),
        .o_z       (cc_z),
        .o_v       (cc_v),
        .o_c       (cc_c)
    );

    // memory port: word address with byte lane picked from bit 0
    // a store requests only once its write enable stands, so no read ack is taken for it
    assign o_mem_req   = (st_r == ST_FETCH) || (st_r == ST_NEXTW) || (st_r == ST_PTR) ||
                         (st_r == ST_OPRD) || ((st_r == ST_WRITE) && mwe_r);
    assign o_mem_we    = mwe_r;
    assign o_mem_addr  = {maddr_r[15:1], 1'b0};
    assign o_mem_wdata = mwdata_r;
    assign o_trace_trap = (st_r == ST_DONE) && psw_r[`PSW_TRACE];
    assign o_activity  = act_r;
    assign o_busy      = (st_r != ST_IDLE);

    // byte view of the returned word
    wire [15:0] word_memory_view = i_mem_rdata;
    wire [15:0] byte_view = maddr_r[0] ? {8'h00, i_mem_rdata[15:8]}
                                       : {8'h00, i_mem_rdata[7:0]};
    wire        word_odd  = maddr_r[0] && (is_byte_access == 1'b0);
    wire        stk_low   = (cur_reg == 3'd6) && (gpr_r[6] < `STACK_LIMIT);

    // access width of the current memory cycle
    always @* begin
        is_byte_access = 1'b0;
        if (st_r == ST_OPRD || st_r == ST_WRITE) begin
            is_byte_access = is_byte && !jump_dst;
        end
    end

    // main sequencer: fetch, resolve source, resolve destination, execute
    always @(posedge i_clk) begin
        if (i_reset) begin
            psw_r     <= `PSW_RESET;
            flags_r   <= 6'h00;
            act_r     <= `ACT_RUN;
            st_r      <= ST_IDLE;
            phase_r   <= ST_SRC;
            instr_r   <= 16'h0000;
            ea_r      <= 16'h0000;
            src_val_r <= 16'h0000;
            dst_val_r <= 16'h0000;
            maddr_r   <= 16'h0000;
            mwe_r     <= 1'b0;
            mwdata_r  <= 16'h0000;
            tmo_cnt_r <= 16'h0000;
            pf_sync_r <= 3'h0;
            pu_sync_r <= 3'h0;
            pf_last_r <= 1'b0;
            pu_last_r <= 1'b0;
            o_reg_rdata <= 16'h0000;
            // a known program counter avoids a fetch from an unknown address
            for (j = 0; j < 8; j = j + 1) gpr_r[j] <= 16'h0000;
        end else if (i_ce) begin
            // power inputs come from outside: three stages, second and third agree
            pf_sync_r <= {pf_sync_r[1:0], i_power_low};
            pu_sync_r <= {pu_sync_r[1:0], i_power_ok};
            if (pf_sync_r[2] == pf_sync_r[1]) pf_last_r <= pf_sync_r[2];
            if (pu_sync_r[2] == pu_sync_r[1]) pu_last_r <= pu_sync_r[2];

            // register port read, data one cycle later
            o_reg_rdata <= 16'h0000;
            if (i_reg_rd) begin
                if (i_reg_addr[3]) o_reg_rdata <= gpr_r[i_reg_addr[2:0]];
                else case (i_reg_addr)
                    `OFF_PSW:   o_reg_rdata <= {8'h00, psw_r[7:0]};
                    `OFF_FLAGS: o_reg_rdata <= {10'h000, flags_r};
                    `OFF_CTRL:  o_reg_rdata <= {15'h0000, o_busy};
                    `OFF_ACT:   o_reg_rdata <= {14'h0000, act_r};
                    default:    o_reg_rdata <= 16'h0000;
                endcase
            end
            // writes; a write of one clears a flag, but a new event wins
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `OFF_PSW:   psw_r <= {8'h00, i_reg_wdata[7:0]};
                    `OFF_FLAGS: flags_r <= flags_r & ~i_reg_wdata[5:0];
                    `OFF_ACT:   if (i_reg_wdata[1:0] != 2'h3) act_r <= i_reg_wdata[1:0];
                    default:    ;
                endcase
            end
            if (pf_sync_r[2] == pf_sync_r[1] && pf_sync_r[2] && !pf_last_r)
                flags_r[`FLG_PWRFAIL] <= 1'b1;
            if (pu_sync_r[2] == pu_sync_r[1] && pu_sync_r[2] && !pu_last_r) begin
                flags_r[`FLG_PWRUP] <= 1'b1;
                act_r <= `ACT_RUN;
            end

            // outstanding access time-out
            if (o_mem_req && !i_mem_ack) begin
                tmo_cnt_r <= tmo_cnt_r + 16'h0001;
                if (tmo_cnt_r == TIMEOUT_CYCLES[15:0] - 16'h0001) begin
                    flags_r[`FLG_TIMEOUT] <= 1'b1;
                    st_r      <= ST_DONE;
                    mwe_r     <= 1'b0;
                    tmo_cnt_r <= 16'h0000;
                end
            end else begin
                tmo_cnt_r <= 16'h0000;
            end

            case (st_r)
                ST_IDLE: begin
                    if (act_r == `ACT_RUN) begin
                        maddr_r <= gpr_r[7];
                        st_r    <= ST_FETCH;
                    end
                end
                ST_FETCH: if (i_mem_ack) begin
                    instr_r <= i_mem_rdata;
                    phase_r <= ST_SRC;
                    st_r    <= ST_DEC;
                    // an odd program counter is a word access on an odd byte: abandon it
                    if (word_odd) begin
                        flags_r[`FLG_BOUND] <= 1'b1;
                        st_r <= ST_DONE;
                    end
                end
                ST_DEC: begin
                    // one-operand forms skip the source step
                    if (!is_move && !is_jump) begin
                        st_r <= ST_DONE; // other classes executed elsewhere
                    end else if (jump_dst || (is_jump && phase_r == ST_SRC)) begin
                        phase_r <= ST_DST;
                        if (dst_mode == 3'd0) begin
                            flags_r[`FLG_ILLEGAL] <= 1'b1;
                            st_r <= ST_DONE;
                        end else begin
                            st_r <= ST_DEC;
                        end
                        if (phase_r == ST_DST && dst_mode != 3'd0) begin
                            st_r <= (dst_mode[2:1] == 2'b11) ? ST_NEXTW : ST_PTR;
                            maddr_r <= (dst_mode[2:1] == 2'b11) ? gpr_r[7] : gpr_r[dst_reg];
                        end
                    end else case (cur_mode)
                        3'd0: begin
                            if (phase_r == ST_SRC) begin
                                src_val_r <= selected_register;
                                phase_r   <= ST_DST;
                            end else begin
                                st_r <= ST_WRITE;
                            end
                        end
                        3'd1, 3'd2, 3'd3: begin
                            maddr_r <= selected_register;
                            st_r    <= cur_mode[0] && cur_mode[1] ? ST_PTR : ST_OPRD;
                            if (cur_mode[1]) gpr_r[cur_reg] <= selected_register +
                                (cur_mode[0] ? 16'h0002 : operand_step);
                        end
                        3'd4, 3'd5: begin
                            maddr_r <= selected_register - (cur_mode[0] ? 16'h0002
                                                                        : operand_step);
                            gpr_r[cur_reg] <= selected_register - (cur_mode[0] ? 16'h0002
                                                    : operand_step);
                            st_r <= cur_mode[0] ? ST_PTR : ST_OPRD;
                        end
                        default: begin
                            maddr_r <= gpr_r[7];
                            st_r    <= ST_NEXTW;
                        end
                    endcase
                end
                ST_NEXTW: if (i_mem_ack) begin
                    // PC advances by 2 in this same cycle; PC-relative adds the word to that PC+2 value
                    gpr_r[7] <= gpr_r[7] + 16'h0002;
                    maddr_r  <= following_word + ((cur_reg == 3'd7) ?
                                gpr_r[7] + 16'h0002 : selected_register);
                    st_r <= cur_mode[0] ? ST_PTR : ST_OPRD;
                    if (jump_dst && !cur_mode[0]) begin
                        ea_r <= following_word + ((cur_reg == 3'd7) ?
                                gpr_r[7] + 16'h0002 : selected_register);
                        st_r <= ST_DONE;
                    end
                end
                ST_PTR: if (i_mem_ack) begin
                    maddr_r <= word_memory_view;
                    if (word_odd) flags_r[`FLG_BOUND] <= 1'b1;
                    if (jump_dst) begin
                        ea_r <= cur_mode[0] ? word_memory_view : maddr_r;
                        if (dst_mode == 3'd2 || dst_mode == 3'd3)
                            gpr_r[dst_reg] <= gpr_r[dst_reg] + 16'h0002;
                        if (dst_mode == 3'd4 || dst_mode == 3'd5)
                            ea_r <= cur_mode[0] ? word_memory_view : maddr_r - 16'h0002;
                        st_r <= ST_DONE;
                    end else begin
                        st_r <= ST_OPRD;
                    end
                end
                ST_OPRD: if (i_mem_ack) begin
                    if (word_odd) flags_r[`FLG_BOUND] <= 1'b1;
                    if (stk_low && cur_word) flags_r[`FLG_STKOVF] <= 1'b1;
                    if (phase_r == ST_SRC) begin
                        src_val_r <= is_byte ? byte_view : word_memory_view;
                        phase_r   <= ST_DST;
                        st_r      <= ST_DEC;
                    end else begin
                        dst_val_r <= word_memory_view;
                        st_r      <= ST_WRITE;
                    end
                    if (word_odd) st_r <= ST_DONE;
                end
                ST_WRITE: begin
                    // move word: flags and destination store
                    psw_r[`PSW_N] <= cc_n;
                    psw_r[`PSW_Z] <= cc_z;
                    psw_r[`PSW_V] <= cc_v;
                    if (dst_mode == 3'd0) begin
                        gpr_r[dst_reg] <= src_val_r;
                        st_r <= ST_DONE;
                    end else begin
                        mwe_r    <= 1'b1;
                        mwdata_r <= src_val_r;
                        if (i_mem_ack) begin
                            mwe_r <= 1'b0;
                            st_r  <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    gpr_r[7] <= gpr_r[7] + 16'h0002;
                    mwe_r    <= 1'b0; // a store cut by the time-out must not linger
                    if (jump_dst && !flags_r[`FLG_ILLEGAL]) gpr_r[7] <= ea_r;
                    st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
            // software writes to general registers win over the sequencer
            if (i_reg_wr && i_reg_addr[3]) gpr_r[i_reg_addr[2:0]] <= i_reg_wdata;
        end
    end

endmodule

// [verification/mem_model.sv]
`timescale 1ns/1ps
// word memory on the far side; addresses with bit 15 set do not exist
module mem_model (
    input  wire        i_clk,
    input  wire        i_req,
    input  wire        i_we,
    input  wire [15:0] i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_slow,
    output reg         o_ack,
    output reg  [15:0] o_rdata
);
    reg [15:0] mem [0:255];
    reg [1:0]  wait_r;
    integer    k;
    // every word holds a move of register 0 into register 1
    initial begin
        for (k = 0; k < 256; k = k + 1) mem[k] = 16'h1001;
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        wait_r = 2'h0;
    end
    // data toggle outside ack so a stale value is never mistaken for a read
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack && !i_addr[15]) begin
            if (wait_r < {i_slow, 1'b0}) begin
                wait_r <= wait_r + 2'h1;
            end else begin
                wait_r <= 2'h0;
                o_ack <= 1'b1;
                o_rdata <= mem[i_addr[8:1]];
                if (i_we) mem[i_addr[8:1]] <= i_wdata;
            end
        end
    end
endmodule

// [verification/operand_address_decoder_sva.sv]
`timescale 1ns/1ps
`include "opdec_consts.vh"
// port checker for the decoder
module operand_address_decoder_sva #(
    parameter TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_ce,
    input wire [3:0]  i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire        i_reg_wr,
    input wire        i_reg_rd,
    input wire [15:0] o_reg_rdata,
    input wire        o_mem_req,
    input wire [15:0] o_mem_addr,
    input wire        i_mem_ack,
    input wire        o_trace_trap,
    input wire [1:0]  o_activity,
    input wire        o_busy
);
    reg [15:0] pend_cnt_r;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // cycles the current access has waited; the decoder gives up after the last one
    always @(posedge i_clk) begin
        if (i_reset) pend_cnt_r <= 16'h0000;
        else if (i_ce) pend_cnt_r <= (o_mem_req && !i_mem_ack) ? pend_cnt_r + 16'h0001
                                                                : 16'h0000;
    end
    // low registers only, while halted and idle, so execution cannot rewrite them
    sequence gpr_wr_s;
        i_reg_wr && i_ce && i_reg_addr >= 4'h8 && i_reg_addr < 4'hE &&
        o_activity == 2'h2 && !o_busy;
    endsequence
    sequence gpr_rd_s;
        i_reg_rd && i_ce && i_reg_addr == $past(i_reg_addr, 2);
    endsequence
    a_rdata_only_after: assert property (i_ce && !i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (i_reg_rd && i_ce && i_reg_addr[3:2] == 2'h1
        |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_psw_top_zero: assert property (i_reg_rd && i_ce && i_reg_addr == `OFF_PSW
        |=> o_reg_rdata[15:8] == 8'h00) else $error("status top byte set");
    a_act_legal: assert property (o_activity != 2'h3)
        else $error("activity value 3");
    a_mem_hold: assert property (o_mem_req && !i_mem_ack && pend_cnt_r != TIMEOUT_CYCLES - 1
        |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request dropped before ack");
    a_addr_even: assert property (o_mem_req |-> !o_mem_addr[0])
        else $error("odd word address on bus");
    a_gpr_readback: assert property (gpr_wr_s ##1 !i_reg_wr ##1 gpr_rd_s
        |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("register readback");
    a_trap_pulse: assert property (o_trace_trap |=> !o_trace_trap)
        else $error("trace trap longer than one cycle");
endmodule
bind operand_address_decoder operand_address_decoder_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
    .o_trace_trap(o_trace_trap), .o_activity(o_activity), .o_busy(o_busy));

// [verification/tb_operand_address_decoder.sv]
`timescale 1ns/1ps
`include "opdec_consts.vh"
module tb_operand_address_decoder;
    reg         i_clk, i_reset, i_reg_wr, i_reg_rd, i_power_low, i_power_ok, slow;
    reg  [3:0]  i_reg_addr;
    reg  [15:0] i_reg_wdata, got, traps;
    integer     mismatches, checks, i;
    wire [15:0] o_reg_rdata, o_mem_addr, o_mem_wdata, mem_rdata;
    wire        o_mem_req, o_mem_we, mem_ack, o_trace_trap, o_busy;
    wire [1:0]  o_activity;
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // short bus time-out keeps the run brief
    operand_address_decoder #(.TIMEOUT_CYCLES(16)) uut (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req),
        .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .i_power_low(i_power_low),
        .i_power_ok(i_power_ok), .o_trace_trap(o_trace_trap), .o_activity(o_activity),
        .o_busy(o_busy));
    mem_model mem (.i_clk(i_clk), .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
        .i_wdata(o_mem_wdata), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));
    // trace traps seen, one per cycle the pulse stands
    always @(posedge i_clk) begin
        if (i_reset) traps <= 16'h0000;
        else if (o_trace_trap === 1'b1) traps <= traps + 16'h0001;
    end
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_wdata <= d;
            i_reg_wr <= 1'b1;
            @(posedge i_clk);
            i_reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [3:0] a);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_rd <= 1'b1;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            #1 got = o_reg_rdata;
        end
    endtask
    task chk(input [63:0] n, input [15:0] e, input [15:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // halt and let the current instruction finish; busy is read once settled
    task halt;
        integer w;
        begin
            wr(`OFF_ACT, {14'h0, `ACT_OFF});
            #1;
            for (w = 0; w < 40 && o_busy !== 1'b0; w = w + 1) begin
                @(posedge i_clk);
                #1;
            end
        end
    endtask
    // run from a given program counter, then halt
    task run_for(input [15:0] pc, input integer n);
        begin
            wr(4'hF, pc);
            wr(`OFF_ACT, {14'h0, `ACT_RUN});
            repeat (n) @(posedge i_clk);
            halt;
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        mismatches = mismatches + 1;
        complete_run;
    end
    initial begin
        mismatches = 0;
        checks = 0;
        {i_reg_wr, i_reg_rd, i_power_low, i_power_ok, slow} = 5'h00;
        i_reg_addr = 4'h0;
        i_reg_wdata = 16'h0000;
        i_reset = 1'b1;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        halt;
        for (i = 0; i < 6; i = i + 1) begin
            wr(4'h8 + i, 16'h1357 * (i + 1));
            rd(4'h8 + i);
            chk("gpr_now", 16'h1357 * (i + 1), got);
        end
        for (i = 0; i < 6; i = i + 1) begin
            rd(4'h8 + i);
            chk("gpr", 16'h1357 * (i + 1), got);
        end
        for (i = 4; i < 8; i = i + 1) begin
            rd(i);
            chk("unmapped", 16'h0000, got);
        end
        rd(`OFF_PSW);
        chk("psw_top", 16'h0000, got & 16'hFF00);
        wr(`OFF_ACT, 16'h0003);
        rd(`OFF_ACT);
        chk("act_rd", 16'h0002, got);
        chk("act_pin", 16'h0002, {14'h0000, o_activity});
        $display("test registers done");
        // negative then zero result, prompt then slow memory
        for (i = 0; i < 2; i = i + 1) begin
            slow <= i;
            wr(4'h8, i ? 16'h0000 : 16'h8000);
            wr(4'h9, 16'h5A5A);
            run_for(16'h0080, 80);
            rd(4'h9);
            chk("move_dst", i ? 16'h0000 : 16'h8000, got);
            rd(`OFF_PSW);
            chk("psw_nzv", i ? 16'h0004 : 16'h0008, got & 16'h000E);
        end
        $display("test move done");
        chk("notrace", 16'h0000, traps);
        wr(`OFF_PSW, 16'h0010);
        run_for(16'h0080, 40);
        rd(4'hF);
        chk("trace_pc", 16'h0001, {15'h0000, got != 16'h0080});
        chk("traces", (got - 16'h0080) >> 1, traps);
        $display("test trace done");
        wr(`OFF_FLAGS, 16'h003F);
        run_for(16'h8000, 60);
        rd(`OFF_FLAGS);
        chk("timeout", 16'h0004, got & 16'h0004);
        wr(`OFF_FLAGS, 16'h003F);
        run_for(16'h0081, 20);
        rd(`OFF_FLAGS);
        chk("boundary", 16'h0001, got & 16'h0001);
        $display("test bus errors done");
        wr(`OFF_FLAGS, 16'h003F);
        i_power_low <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(`OFF_FLAGS);
        chk("pwrfail", 16'h0010, got & 16'h0030);
        i_power_ok <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(`OFF_FLAGS);
        chk("pwrup", 16'h0020, got & 16'h0020);
        chk("act_up", 16'h0000, {14'h0000, o_activity});
        halt;
        wr(`OFF_FLAGS, 16'h003F);
        rd(`OFF_FLAGS);
        chk("flag_clr", 16'h0000, got & 16'h003F);
        $display("test power done");
        complete_run;
    end
endmodule
